// *** inc/amg_pkg.sv ***
package amg_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] AMG_IDX_AUX1 = 8'h04;
	localparam logic [7:0] AMG_IDX_AUX2 = 8'h05;
	localparam logic [7:0] AMG_IDX_CTRL = 8'h06;
	localparam logic [11:0] AMG_ADDR_AUX1 = {2'b00, AMG_IDX_AUX1, 2'b00};
	localparam logic [11:0] AMG_ADDR_AUX2 = {2'b00, AMG_IDX_AUX2, 2'b00};
	localparam logic [11:0] AMG_ADDR_CTRL = {2'b00, AMG_IDX_CTRL, 2'b00};
	// Field positions of a mix register
	localparam int AMG_LMUTE_BIT = 15;
	localparam int AMG_RMUTE_BIT = 7;
	localparam int AMG_LGAIN_LSB = 8;
	localparam int AMG_RGAIN_LSB = 0;
	localparam int AMG_GAIN_W = 5;
	// Writable bits: mutes and gains; reserved bits 14,13,6,5 stay zero
	localparam logic [15:0] AMG_WMASK = 16'h9f9f;
	localparam logic [15:0] AMG_MIX_RST = 16'h8888;
	// Control register fields (gating bits)
	localparam int AMG_CONV_OFF_BIT = 0;
	localparam int AMG_MIX_EN_BIT = 1;
	localparam int AMG_ANA_EN_BIT = 2;
	localparam logic [2:0] AMG_CTRL_RST = 3'h0;
	localparam int AMG_SYNC_STAGES = 3;
endpackage

// *** hdl/amg_pin_sync.sv ***
`timescale 1ns/100ps
// Three-stage pin synchroniser; change accepted once stages two and three agree
module amg_pin_sync
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_n,
	output logic level_n
);
	import amg_pkg::*;

	typedef struct packed {
		logic [AMG_SYNC_STAGES-1:0] sh;
		logic lvl;
	} amg_sync_t;

	amg_sync_t st_r;
	amg_sync_t st_nxt;

	// ----------------------------------------
	// Shift and agree
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sh = {st_r.sh[AMG_SYNC_STAGES-2:0], pin_n};
		if (st_r.sh[1] == st_r.sh[2])
			st_nxt.lvl = st_r.sh[2];
	end

	// Reset holds the pin as asserted (low) so the block starts forced
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign level_n = st_r.lvl;
endmodule

// *** hdl/amg_regs.sv ***
`timescale 1ns/100ps
// Behaviour
// - Aux1 bit 15 mutes the left aux1 mix path when one.
// - Aux1 bit 7 mutes the right aux1 mix path when one.
// - Aux1 bits 12:8 left gain, 1.5 dB steps, 01000 is unity.
// - Aux1 bits 4:0 right gain, same coding, 00000 is +12 dB.
// - Aux2 register uses the identical layout and coding.
// - Both registers hold 8888 hex after reset.
// - Reset or power-down pin low forces default and blocks writes to both mix registers.
// - Conversions off, mix disable or analog disable also force default.
module amg_regs
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reset_pin_n,
	input wire logic power_down_pin_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic aux1_left_mute,
	output logic aux1_right_mute,
	output logic [amg_pkg::AMG_GAIN_W-1:0] aux1_left_gain_code,
	output logic [amg_pkg::AMG_GAIN_W-1:0] aux1_right_gain_code,
	output logic aux2_left_mute,
	output logic aux2_right_mute,
	output logic [amg_pkg::AMG_GAIN_W-1:0] aux2_left_gain_code,
	output logic [amg_pkg::AMG_GAIN_W-1:0] aux2_right_gain_code,
	output logic mix_forced
);
	import amg_pkg::*;

	typedef struct packed {
		logic [15:0] aux1;
		logic [15:0] aux2;
		logic [2:0] ctrl;
		logic forced;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} amg_state_t;

	amg_state_t st_r;
	amg_state_t st_nxt;
	logic rst_pin_s;
	logic pwd_pin_s;
	logic force_now;
	logic wr_acc;
	logic rd_acc;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	amg_pin_sync u_sync_rst
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin_n(reset_pin_n),
		.level_n(rst_pin_s)
	);

	amg_pin_sync u_sync_pwd
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin_n(power_down_pin_n),
		.level_n(pwd_pin_s)
	);

	// Merge a 32-bit write word into a 16-bit register by byte strobes
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] sb);
		logic [15:0] v;
		v = old;
		if (sb[0])
			v[7:0] = wd[7:0];
		if (sb[1])
			v[15:8] = wd[15:8];
		return v & AMG_WMASK;
	endfunction

	// ----------------------------------------
	// Force condition and bus decode
	// ----------------------------------------
	// Uses the registered control so a write to it takes effect next cycle
	always_comb
	begin
		force_now = !rst_pin_s || !pwd_pin_s
			|| st_r.ctrl[AMG_CONV_OFF_BIT]
			|| !st_r.ctrl[AMG_MIX_EN_BIT]
			|| !st_r.ctrl[AMG_ANA_EN_BIT];
		wr_acc = psel && penable && pwrite && !st_r.ready;
		rd_acc = psel && penable && !pwrite && !st_r.ready;
	end

	// ----------------------------------------
	// Next state: one wait state, then pready for a single cycle
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ready = psel && penable && !st_r.ready;
		st_nxt.err = 1'b0;
		st_nxt.rdata = 32'h0000_0000;
		if (wr_acc)
		begin
			unique case (paddr)
				AMG_ADDR_AUX1:
					st_nxt.aux1 = merge16(st_r.aux1, pwdata, pstrb);
				AMG_ADDR_AUX2:
					st_nxt.aux2 = merge16(st_r.aux2, pwdata, pstrb);
				AMG_ADDR_CTRL:
					if (pstrb[0])
						st_nxt.ctrl = pwdata[2:0];
				default:
					st_nxt.err = 1'b1;
			endcase
		end
		if (rd_acc)
		begin
			// Reads only sample; nothing changes underneath
			unique case (paddr)
				AMG_ADDR_AUX1:
					st_nxt.rdata = {16'h0000, st_r.aux1};
				AMG_ADDR_AUX2:
					st_nxt.rdata = {16'h0000, st_r.aux2};
				AMG_ADDR_CTRL:
					st_nxt.rdata = {28'h000_0000, st_r.forced, st_r.ctrl};
				default:
					st_nxt.err = 1'b1;
			endcase
		end
		// Forcing wins over any aux1 or aux2 write in the same cycle
		if (force_now)
		begin
			st_nxt.aux1 = AMG_MIX_RST;
			st_nxt.aux2 = AMG_MIX_RST;
		end
		st_nxt.forced = force_now;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.aux1 <= AMG_MIX_RST;
			st_r.aux2 <= AMG_MIX_RST;
			st_r.ctrl <= AMG_CTRL_RST;
			st_r.forced <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------
	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = st_r.err;
	assign mix_forced = st_r.forced;
	assign aux1_left_mute = st_r.aux1[AMG_LMUTE_BIT];
	assign aux1_right_mute = st_r.aux1[AMG_RMUTE_BIT];
	assign aux1_left_gain_code =
		st_r.aux1[AMG_LGAIN_LSB +: AMG_GAIN_W];
	assign aux1_right_gain_code =
		st_r.aux1[AMG_RGAIN_LSB +: AMG_GAIN_W];
	assign aux2_left_mute = st_r.aux2[AMG_LMUTE_BIT];
	assign aux2_right_mute = st_r.aux2[AMG_RMUTE_BIT];
	assign aux2_left_gain_code = st_r.aux2[AMG_LGAIN_LSB +: AMG_GAIN_W];
	assign aux2_right_gain_code = st_r.aux2[AMG_RGAIN_LSB +: AMG_GAIN_W];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_forced_default: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.forced |-> st_r.aux1 == AMG_MIX_RST && st_r.aux2 == AMG_MIX_RST)
		else $error("forced registers not at default");
	a_ctrl_force: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.ctrl[AMG_CONV_OFF_BIT] |=> mix_forced)
		else $error("conversions off did not force");
	a_mix_en_force: assert property (@(posedge pclk)
		disable iff (!presetn)
		!st_r.ctrl[AMG_MIX_EN_BIT] |=> mix_forced)
		else $error("mix disable did not force");
	a_ana_en_force: assert property (@(posedge pclk)
		disable iff (!presetn)
		!st_r.ctrl[AMG_ANA_EN_BIT] |=> aux1_left_mute && aux2_right_mute)
		else $error("analog disable did not mute");
	// Synchronised pin levels are the trigger, not the raw pins
	a_pin_force: assert property (@(posedge pclk)
		disable iff (!presetn)
		!rst_pin_s || !pwd_pin_s |=> mix_forced)
		else $error("pin low did not force");
	a_write_lands: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr_acc && paddr == AMG_ADDR_AUX1 && pstrb == 4'hf && !force_now
		|=> st_r.aux1 == (pwdata[15:0] & AMG_WMASK) && pready)
		else $error("aux1 write lost");
	a_reserved_zero: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_r.aux1 & ~AMG_WMASK) == 16'h0000
		&& (st_r.aux2 & ~AMG_WMASK) == 16'h0000)
		else $error("reserved bits set");
	a_read_stable: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_acc && !force_now |=> $stable(st_r.aux2) && $stable(st_r.aux1))
		else $error("read changed register");
	a_read_data: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_acc && paddr == AMG_ADDR_AUX2 |=> prdata[15:0] == $past(st_r.aux2))
		else $error("aux2 read data wrong");
	// Default gain code on the pins is the unity step
	a_gain_field: assert property (@(posedge pclk)
		disable iff (!presetn)
		mix_forced |-> aux1_left_gain_code == 5'h08
		&& aux2_right_gain_code == 5'h08)
		else $error("gain field misplaced");
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready longer than one cycle");
	c_write_aux1: cover property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == AMG_ADDR_AUX1 && !force_now);
	c_read_aux2: cover property (@(posedge pclk) disable iff (!presetn)
		rd_acc && paddr == AMG_ADDR_AUX2);
	c_force_rise: cover property (@(posedge pclk) disable iff (!presetn)
		!mix_forced ##1 mix_forced);
endmodule

// *** verif/aux_mix_gain_control_regs_bench.sv ***
`timescale 1ns/100ps
module aux_mix_gain_control_regs_bench;
	import amg_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, reset_pin_n = 1'b1;
	logic power_down_pin_n = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, mix_forced, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic [3:0] pstrb = 4'hf;
	logic l1m, r1m, l2m, r2m;
	logic [4:0] l1g, r1g, l2g, r2g;
	int fails = 0, checks = 0;
	// ----------------------------------------
	// Clock and device under test
	// ----------------------------------------
	always #12.5 pclk = ~pclk;
	amg_regs dut (.pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
		.power_down_pin_n(power_down_pin_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.aux1_left_mute(l1m), .aux1_right_mute(r1m),
		.aux1_left_gain_code(l1g), .aux1_right_gain_code(r1g),
		.aux2_left_mute(l2m), .aux2_right_mute(r2m),
		.aux2_left_gain_code(l2g), .aux2_right_gain_code(r2g),
		.mix_forced(mix_forced));
	// ----------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a hung wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] exp);
		xfer(1'b0, a, '0);
		chk(q, {16'h0000, exp});
		chk(err, 1'b0);
	endtask
	// Field view of a register value: mute, gain, mute, gain
	function automatic logic [11:0] fld(input logic [15:0] v);
		return {v[15], v[12:8], v[7], v[4:0]};
	endfunction
	// Make both registers non-default so that forcing is visible
	task automatic go_live();
		xfer(1'b1, AMG_ADDR_CTRL, 32'h0000_0006);
		repeat (4) @(posedge pclk);
		xfer(1'b1, AMG_ADDR_AUX1, 32'h0000_1f07);
		xfer(1'b1, AMG_ADDR_AUX2, 32'h0000_0a95);
	endtask
	task automatic wrap_up();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// Watchdog: the tests need well under 1000 cycles
	// ----------------------------------------
	initial
	begin
		#125000;
		fails++;
		wrap_up();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(AMG_ADDR_AUX1, 16'h8888);
		rd(AMG_ADDR_AUX2, 16'h8888);
		rd(AMG_ADDR_CTRL, 16'h0008);
		go_live();
		rd(AMG_ADDR_CTRL, 16'h0006);
		rd(AMG_ADDR_AUX1, 16'h1f07);
		chk(fld(16'h1f07), {l1m, l1g, r1m, r1g});
		rd(AMG_ADDR_AUX2, 16'h0a95);
		chk(fld(16'h0a95), {l2m, l2g, r2m, r2g});
		xfer(1'b1, AMG_ADDR_AUX1, 32'h0000_8080);
		rd(AMG_ADDR_AUX1, 16'h8080);
		rd(AMG_ADDR_AUX1, 16'h8080);
		chk(fld(16'h8080), {l1m, l1g, r1m, r1g});
		xfer(1'b0, 12'h020, '0);
		chk(err, 1'b1);
		// Each cause of forcing in turn: three control codes, two pins
		for (int k = 0; k < 5; k++)
		begin
			go_live();
			if (k == 0)
				xfer(1'b1, AMG_ADDR_CTRL, 32'h0000_0007);
			else if (k == 1)
				xfer(1'b1, AMG_ADDR_CTRL, 32'h0000_0004);
			else if (k == 2)
				xfer(1'b1, AMG_ADDR_CTRL, 32'h0000_0002);
			else if (k == 3)
				reset_pin_n <= 1'b0;
			else
				power_down_pin_n <= 1'b0;
			repeat (8) @(posedge pclk);
			xfer(1'b1, AMG_ADDR_AUX2, 32'h0000_1f07);
			rd(AMG_ADDR_AUX1, 16'h8888);
			rd(AMG_ADDR_AUX2, 16'h8888);
			chk(mix_forced, 1'b1);
			chk(fld(16'h8888), {l2m, l2g, r2m, r2g});
			reset_pin_n <= 1'b1;
			power_down_pin_n <= 1'b1;
			repeat (8) @(posedge pclk);
		end
		wrap_up();
	end
endmodule
